// file: verilog/ssc_pkg.sv
// Constants shared by the sensor sync and mode control block
package ssc_pkg;

   // ==========================================================
   // Register offsets (byte addresses on APB)
   localparam logic [11:0] SYNC_CONTROL_OFS = 12'h000;
   localparam logic [11:0] MODE_SETUP_OFS   = 12'h004;

   // ==========================================================
   // Reset values and writable-bit masks
   localparam logic [31:0] SYNC_CONTROL_RST = 32'h0000_0000;
   localparam logic [31:0] MODE_SETUP_RST   = 32'h0000_0000;
   localparam logic [31:0] SYNC_CONTROL_WM  = 32'h0000_0003;
   localparam logic [31:0] MODE_SETUP_WM    = 32'h0000_77FF;

   // ==========================================================
   // Field positions
   localparam int SC_SYNC_GEN_EN_BIT = 0;
   localparam int SC_RAW_WR_EN_BIT   = 1;
   localparam int MS_SYNC_DIR_BIT    = 0;
   localparam int MS_SHIFT_LSB       = 8;
   localparam int MS_SHIFT_MSB       = 10;
   localparam int MS_FORMAT_LSB      = 12;
   localparam int MS_FORMAT_MSB      = 13;
   localparam int MS_LOWPASS_BIT     = 14;
   localparam int MS_FIELD_BIT       = 15;

   // ==========================================================
   // Input formats
   localparam logic [1:0] FMT_RAW  = 2'h0;
   localparam logic [1:0] FMT_YC16 = 2'h1;
   localparam logic [1:0] FMT_YC8  = 2'h2;
   localparam logic [1:0] FMT_RSVD = 2'h3;

   // ==========================================================
   // Data path and timing generator sizes
   localparam int          PIX_W       = 16;
   localparam int          FIFO_DEPTH  = 32;
   localparam int          LVL_W       = 6;
   localparam logic [5:0]  FIFO_FULL_L = 6'h20;
   localparam logic [11:0] LINE_PIXELS = 12'h064;
   localparam logic [11:0] FRAME_LINES = 12'h020;

endpackage : ssc_pkg

// file: verilog/ssc_sync_mode_ctrl.sv
// Sensor sync enable, mode setup, raw data path and write FIFO
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps

// ==========================================================
// Synchronous FIFO with registered count
module ssc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   // System
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   // Fill side
   input  wire logic                       inValid,
   output logic                            inReady,
   input  wire logic [WIDTH-1:0]           inData,
   // Drain side
   output logic                            outValid,
   input  wire logic                       outReady,
   output logic      [WIDTH-1:0]           outData,
   // Fill level
   output logic      [$clog2(DEPTH+1)-1:0] level
);
   // Pointers wrap by overflow, so DEPTH must be a power of two
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0]    wrPtr_reg;
   logic [PW-1:0]    wrPtr_next;
   logic [PW-1:0]    rdPtr_reg;
   logic [PW-1:0]    rdPtr_next;
   logic [CW-1:0]    count_reg;
   logic [CW-1:0]    count_next;
   logic             push;
   logic             pop;

   always_comb begin
      inReady    = (count_reg != CW'(DEPTH));
      outValid   = (count_reg != '0);
      outData    = mem[rdPtr_reg];
      level      = count_reg;
      push       = inValid && inReady;
      pop        = outValid && outReady;
      wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
      rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
      count_next = count_reg + CW'(push) - CW'(pop);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         count_reg <= '0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         count_reg <= count_next;
      end
   end

   // Storage carries no reset; only the count register defines validity
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_reg] <= inData;
      end
   end

endmodule : ssc_fifo

// ==========================================================
// Top: APB registers, sync timing generator, raw data path
module ssc_sync_mode_ctrl (
   // System
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Sensor input
   input  wire logic [15:0] pixIn,
   input  wire logic        pixValid,
   output logic             pixReady,
   input  wire logic        vsyncIn,
   input  wire logic        hsyncIn,
   input  wire logic        fieldIn,
   // Sync outputs
   output logic             vsyncOut,
   output logic             hsyncOut,
   output logic             syncOe,
   // Memory write stream
   output logic      [15:0] memData,
   output logic             memValid,
   input  wire logic        memReady
);

   // ==========================================================
   // Declarations
   logic [31:0] syncCtrl_reg, syncCtrl_next;
   logic [31:0] modeSetup_reg, modeSetup_next;
   logic [31:0] prdata_reg, prdata_next;
   logic        pready_reg, pready_next;
   logic        pslverr_reg, pslverr_next;
   logic        rawWrAct_reg, rawWrAct_next;
   logic        lowpassAct_reg, lowpassAct_next;
   logic        field_reg, field_next;
   logic [11:0] hCnt_reg, hCnt_next;
   logic [11:0] vCnt_reg, vCnt_next;
   logic        vsPrev_reg;
   logic        hsPrev_reg;
   logic        hsOut_reg, hsOut_next;
   logic        vsOut_reg, vsOut_next;
   logic        oe_reg, oe_next;
   logic [15:0] prev1_reg, prev1_next;
   logic [15:0] prev2_reg, prev2_next;
   logic        pixReady_reg, pixReady_next;
   logic [15:0] memData_reg, memData_next;
   logic        memValid_reg, memValid_next;

   logic        access;
   logic        hit;
   logic [31:0] rdValue;
   logic        syncGenEn;
   logic        syncDirOut;
   logic [1:0]  format;
   logic [2:0]  shiftAmt;
   logic        frameEvent;
   logic        hsRise;
   logic        vsRise;
   logic        accept;
   logic [17:0] filtSum;
   logic [15:0] procPix;
   logic [15:0] storePix;
   logic        fifoInValid;
   logic        fifoInReady;
   logic        fifoOutValid;
   logic        fifoOutReady;
   logic [15:0] fifoOutData;
   logic [5:0]  fifoLevel;

   assign syncGenEn  = syncCtrl_reg[ssc_pkg::SC_SYNC_GEN_EN_BIT];
   assign syncDirOut = modeSetup_reg[ssc_pkg::MS_SYNC_DIR_BIT];
   assign format     = modeSetup_reg[ssc_pkg::MS_FORMAT_MSB:ssc_pkg::MS_FORMAT_LSB];
   assign shiftAmt   = modeSetup_reg[ssc_pkg::MS_SHIFT_MSB:ssc_pkg::MS_SHIFT_LSB];

   // ==========================================================
   // APB register file: one wait state, answer registered
   always_comb begin
      access         = psel && penable;
      hit            = (paddr == ssc_pkg::SYNC_CONTROL_OFS) || (paddr == ssc_pkg::MODE_SETUP_OFS);
      rdValue        = 32'h0000_0000;
      if (paddr == ssc_pkg::SYNC_CONTROL_OFS) begin
         rdValue = syncCtrl_reg;
      end else if (paddr == ssc_pkg::MODE_SETUP_OFS) begin
         rdValue                         = modeSetup_reg;
         rdValue[ssc_pkg::MS_FIELD_BIT]  = field_reg;
      end
      syncCtrl_next  = syncCtrl_reg;
      modeSetup_next = modeSetup_reg;
      pready_next    = access && !pready_reg;
      pslverr_next   = access && !pready_reg && !hit;
      prdata_next    = (access && !pready_reg && !pwrite) ? rdValue : 32'h0000_0000;
      // Write lands at the edge that completes the access
      if (access && pready_reg && pwrite) begin
         if (paddr == ssc_pkg::SYNC_CONTROL_OFS) begin
            syncCtrl_next = pwdata & ssc_pkg::SYNC_CONTROL_WM;
         end else if (paddr == ssc_pkg::MODE_SETUP_OFS) begin
            modeSetup_next = pwdata & ssc_pkg::MODE_SETUP_WM;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         syncCtrl_reg  <= ssc_pkg::SYNC_CONTROL_RST;
         modeSetup_reg <= ssc_pkg::MODE_SETUP_RST;
         prdata_reg    <= 32'h0000_0000;
         pready_reg    <= 1'b0;
         pslverr_reg   <= 1'b0;
      end else begin
         syncCtrl_reg  <= syncCtrl_next;
         modeSetup_reg <= modeSetup_next;
         prdata_reg    <= prdata_next;
         pready_reg    <= pready_next;
         pslverr_reg   <= pslverr_next;
      end
   end

   // ==========================================================
   // Sync timing generator
   always_comb begin
      hsRise     = hsyncIn && !hsPrev_reg;
      vsRise     = vsyncIn && !vsPrev_reg;
      hCnt_next  = hCnt_reg;
      vCnt_next  = vCnt_reg;
      frameEvent = 1'b0;
      field_next = field_reg;
      if (!syncGenEn) begin
         hCnt_next = 12'h000;
         vCnt_next = 12'h000;
      end else if (syncDirOut) begin
         // Free-running generator; a pixel count left past the end by input mode wraps at once, a line count at the next line end
         frameEvent = (hCnt_reg == 12'h000) && (vCnt_reg == 12'h000);
         if (hCnt_reg >= ssc_pkg::LINE_PIXELS - 12'h001) begin
            hCnt_next = 12'h000;
            if (vCnt_reg >= ssc_pkg::FRAME_LINES - 12'h001) begin
               vCnt_next = 12'h000;
            end else begin
               vCnt_next = vCnt_reg + 12'h001;
            end
         end else begin
            hCnt_next = hCnt_reg + 12'h001;
         end
         if (frameEvent) begin
            field_next = !field_reg;
         end
      end else begin
         // Counters restart on the external edges
         frameEvent = vsRise;
         hCnt_next = hsRise ? 12'h000 : hCnt_reg + 12'h001;
         if (vsRise) begin
            vCnt_next = 12'h000;
         end else if (hsRise) begin
            vCnt_next = vCnt_reg + 12'h001;
         end
         if (vsRise) begin
            field_next = fieldIn;
         end
      end
      hsOut_next = syncGenEn && syncDirOut && (hCnt_next == 12'h000);
      vsOut_next = syncGenEn && syncDirOut && (vCnt_next == 12'h000);
      oe_next    = syncDirOut;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         hCnt_reg   <= 12'h000;
         vCnt_reg   <= 12'h000;
         hsPrev_reg <= 1'b0;
         vsPrev_reg <= 1'b0;
         hsOut_reg  <= 1'b0;
         vsOut_reg  <= 1'b0;
         oe_reg     <= 1'b0;
         field_reg  <= 1'b0;
      end else begin
         hCnt_reg   <= hCnt_next;
         vCnt_reg   <= vCnt_next;
         hsPrev_reg <= hsyncIn;
         vsPrev_reg <= vsyncIn;
         hsOut_reg  <= hsOut_next;
         vsOut_reg  <= vsOut_next;
         oe_reg     <= oe_next;
         field_reg  <= field_next;
      end
   end

   // ==========================================================
   // Raw data path: frame-latched controls, filter, shift
   always_comb begin
      rawWrAct_next   = rawWrAct_reg;
      lowpassAct_next = lowpassAct_reg;
      if (frameEvent) begin
         rawWrAct_next   = syncCtrl_reg[ssc_pkg::SC_RAW_WR_EN_BIT];
         lowpassAct_next = modeSetup_reg[ssc_pkg::MS_LOWPASS_BIT];
      end
      accept   = pixValid && pixReady_reg;
      filtSum  = {2'b00, prev2_reg} + {1'b0, prev1_reg, 1'b0} + {2'b00, pixIn};
      procPix  = pixIn;
      storePix = pixIn;
      if (format == ssc_pkg::FMT_RAW) begin
         procPix  = lowpassAct_reg ? filtSum[17:2] : pixIn;
         storePix = procPix >> shiftAmt;
      end
      // Reserved format stores nothing
      fifoInValid = accept && rawWrAct_reg && syncGenEn
                    && (format != ssc_pkg::FMT_RSVD);
      prev1_next  = accept ? pixIn : prev1_reg;
      prev2_next  = accept ? prev1_reg : prev2_reg;
      if (frameEvent) begin
         prev1_next = 16'h0000;
         prev2_next = 16'h0000;
      end
      // Ready looks one push ahead so the flag can be a flop
      pixReady_next = (fifoLevel + 6'(fifoInValid && fifoInReady)) < ssc_pkg::FIFO_FULL_L;
      fifoOutReady  = !memValid_reg || memReady;
      memValid_next = memValid_reg;
      memData_next  = memData_reg;
      if (fifoOutReady) begin
         memValid_next = fifoOutValid;
         memData_next  = fifoOutValid ? fifoOutData : memData_reg;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rawWrAct_reg   <= 1'b0;
         lowpassAct_reg <= 1'b0;
         prev1_reg      <= 16'h0000;
         prev2_reg      <= 16'h0000;
         pixReady_reg   <= 1'b0;
         memValid_reg   <= 1'b0;
         memData_reg    <= 16'h0000;
      end else begin
         rawWrAct_reg   <= rawWrAct_next;
         lowpassAct_reg <= lowpassAct_next;
         prev1_reg      <= prev1_next;
         prev2_reg      <= prev2_next;
         pixReady_reg   <= pixReady_next;
         memValid_reg   <= memValid_next;
         memData_reg    <= memData_next;
      end
   end

   // ==========================================================
   // Write buffer toward memory
   ssc_fifo #(
      .WIDTH (ssc_pkg::PIX_W),
      .DEPTH (ssc_pkg::FIFO_DEPTH)
   ) ssc_fifo_i (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .inValid  (fifoInValid),
      .inReady  (fifoInReady),
      .inData   (storePix),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady),
      .outData  (fifoOutData),
      .level    (fifoLevel)
   );

   // ==========================================================
   // Outputs
   assign prdata   = prdata_reg;
   assign pready   = pready_reg;
   assign pslverr  = pslverr_reg;
   assign pixReady = pixReady_reg;
   assign vsyncOut = vsOut_reg;
   assign hsyncOut = hsOut_reg;
   assign syncOe   = oe_reg;
   assign memData  = memData_reg;
   assign memValid = memValid_reg;

endmodule : ssc_sync_mode_ctrl

// file: testbench/ssc_sync_mode_ctrl_sva.sv
// Port-level assertions for the sensor sync and mode control block
`timescale 1ns/10ps
module ssc_sync_mode_ctrl_sva (
   // System
   input wire logic        clk,
   input wire logic        sys_rst,
   // Register bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Streams and syncs
   input wire logic        pixReady,
   input wire logic        hsyncOut,
   input wire logic        vsyncOut,
   input wire logic [15:0] memData,
   input wire logic        memValid,
   input wire logic        memReady
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // ==========================================================
   // Register bus
   apb_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("pready not in second access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   addr_decode_a: assert property (pready |-> pslverr == (paddr != 12'h000 && paddr != 12'h004))
      else $error("pslverr does not match decode");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("prdata not zero outside answer");
   // ==========================================================
   // Stream and syncs
   mem_hold_a: assert property (memValid && !memReady |=> memValid && $stable(memData))
      else $error("memory word dropped while stalled");
   hsync_width_a: assert property (hsyncOut |=> !hsyncOut)
      else $error("hsyncOut wider than one cycle");
   hsync_period_a: assert property (hsyncOut |-> ##100 hsyncOut)
      else $error("hsyncOut period not one line");
   vsync_line_a: assert property ($rose(vsyncOut) |-> ##99 vsyncOut ##1 !vsyncOut)
      else $error("vsyncOut not one line wide");
   // Checked during reset itself, so no disable here
   reset_quiet_a: assert property (disable iff (1'b0) sys_rst |-> !pready && !memValid && !pixReady)
      else $error("outputs active in reset");
   cover property (pready && pslverr);
   cover property (memValid && memReady);
   cover property (!pixReady);
   cover property ($rose(vsyncOut));
endmodule : ssc_sync_mode_ctrl_sva

bind ssc_sync_mode_ctrl ssc_sync_mode_ctrl_sva ssc_sync_mode_ctrl_sva_i (.clk, .sys_rst, .psel, .penable,
   .paddr, .prdata, .pready, .pslverr, .pixReady, .hsyncOut, .vsyncOut, .memData, .memValid, .memReady);

// file: testbench/ssc_sensor_model.sv
// Behavioural image sensor: pixel stream and external syncs
`timescale 1ns/10ps
module ssc_sensor_model (
   // System
   input  wire logic        clk,
   // Pixel stream
   output logic      [15:0] pixIn,
   output logic             pixValid,
   input  wire logic        pixReady,
   // Syncs
   output logic             vsyncIn,
   output logic             hsyncIn,
   output logic             fieldIn
);
   logic [15:0] dat   = 16'h0000;
   logic [15:0] noise = 16'h5A5A;
   initial begin
      pixValid = 1'b0;
      vsyncIn  = 1'b0;
      hsyncIn  = 1'b0;
      fieldIn  = 1'b0;
   end
   // Idle data lines change every cycle so stale data never matches
   always @(posedge clk) noise <= ~noise;
   assign pixIn = pixValid ? dat : noise;
   task automatic send(input logic [15:0] v);
      pixValid <= 1'b1;
      dat      <= v;
      do @(posedge clk); while (pixReady !== 1'b1);
   endtask : send
   task automatic idle();
      pixValid <= 1'b0;
      @(posedge clk);
   endtask : idle
   task automatic vsync(input logic f);
      vsyncIn <= 1'b1;
      hsyncIn <= 1'b1;
      fieldIn <= f;
      repeat (2) @(posedge clk);
      vsyncIn <= 1'b0;
      hsyncIn <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : vsync
endmodule : ssc_sensor_model

// file: testbench/ssc_sync_mode_ctrl_tb.sv
// Self-checking bench for the sensor sync and mode control block
`timescale 1ns/10ps
module ssc_sync_mode_ctrl_tb;
   logic        clk = 1'b0;
   logic        sys_rst = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, memReady = 1'b0, hold = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, seed = 32'h0000_AB53, rv;
   logic [15:0] pixIn, memData, h1, h2;
   logic        pready, pslverr, pixValid, pixReady, vsyncIn, hsyncIn, fieldIn;
   logic        vsyncOut, hsyncOut, syncOe, memValid, en, wen, lpf, regWen, regLpf;
   logic [1:0]  fmt;
   logic [2:0]  shf;
   logic [15:0] expQ[$];
   int          error_cnt = 0, n_checks = 0, cyc = 0, hc, vc, m;

   ssc_sync_mode_ctrl ssc_sync_mode_ctrl_i (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .pixIn, .pixValid, .pixReady, .vsyncIn, .hsyncIn, .fieldIn,
      .vsyncOut, .hsyncOut, .syncOe, .memData, .memValid, .memReady);
   ssc_sensor_model ssc_sensor_model_i (.clk, .pixIn, .pixValid, .pixReady, .vsyncIn, .hsyncIn, .fieldIn);

   always #50 clk = ~clk;

   // ==========================================================
   // Helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk("prdata", r, x);
      chk("pslverr", {31'h0000_0000, e}, {31'h0000_0000, xe});
   endtask : rd
   task automatic cfg(input logic [31:0] s, input logic [31:0] md);
      wr(ssc_pkg::SYNC_CONTROL_OFS, s);
      wr(ssc_pkg::MODE_SETUP_OFS, md);
      en     = s[0];
      regWen = s[1];
      shf    = md[10:8];
      fmt    = md[13:12];
      regLpf = md[14];
   endtask : cfg
   task automatic frame(input logic f);
      ssc_sensor_model_i.vsync(f);
      wen = regWen;
      lpf = regLpf;
      h1  = 16'h0000;
      h2  = 16'h0000;
   endtask : frame
   task automatic burst(input int n);
      logic [17:0] s;
      repeat (n) begin
         rv = xs();
         ssc_sensor_model_i.send(rv[15:0]);
         s = {2'b00, rv[15:0]};
         if (lpf && fmt == ssc_pkg::FMT_RAW) s = ({2'b00, h2} + {1'b0, h1, 1'b0} + s) >> 2;
         if (fmt == ssc_pkg::FMT_RAW) s = s >> shf;
         if (en && wen && fmt != ssc_pkg::FMT_RSVD) expQ.push_back(s[15:0]);
         h2 = h1;
         h1 = rv[15:0];
      end
      ssc_sensor_model_i.idle();
   endtask : burst

   // ==========================================================
   // Output watcher, sink stalls and timeout
   always @(posedge clk) begin
      memReady <= !hold && xs() > 32'h7FFF_FFFF;
      if (memValid === 1'b1 && memReady === 1'b1) begin
         if (expQ.size() == 0) chk("unexpected word", {16'h0000, memData}, 32'hFFFF_FFFF);
         else chk("memData", {16'h0000, memData}, {16'h0000, expQ.pop_front()});
      end
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         complete_run();
      end
   end

   initial begin
      // Reset rises at time zero, so the design is reset before the first edge
      sys_rst <= 1'b1;
      {en, wen, lpf, regWen, regLpf, fmt, shf, h1, h2} = '0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      rd(12'h000, 32'h0000_0000, 1'b0);
      rd(12'h004, 32'h0000_0000, 1'b0);
      // Mode first, so no generator runs while bits are probed
      wr(12'h004, 32'h0000_F7FF);
      rd(12'h004, 32'h0000_77FF, 1'b0);
      wr(12'h004, 32'h0000_0000);
      wr(12'h000, 32'h0000_0003);
      rd(12'h000, 32'h0000_0003, 1'b0);
      rd(12'h008, 32'h0000_0000, 1'b1);
      cfg(3, 0);
      burst(4);
      for (int i = 0; i < 12; i++) begin
         m = i < 8 ? i << 8 : ((i - 7) % 4) << 12 | 5 << 8;
         cfg(3, m);
         frame(i[0]);
         rd(12'h004, m | (i % 2) << 15, 1'b0);
         burst(3);
      end
      cfg(3, 32'h0000_4000);
      frame(1'b0);
      burst(6);
      cfg(3, 0);
      burst(3);
      cfg(1, 0);
      burst(3);
      frame(1'b1);
      burst(3);
      cfg(3, 0);
      frame(1'b0);
      hold = 1'b1;
      fork
         burst(40);
         begin
            repeat (60) @(posedge clk);
            chk("pixReady", {31'h0000_0000, pixReady}, 32'h0000_0000);
            hold = 1'b0;
         end
      join
      for (int k = 0; k < 500 && expQ.size() > 0; k++) @(posedge clk);
      chk("words left", expQ.size(), 0);
      cfg(1, 1);
      hc = 0;
      vc = 0;
      repeat (3200) begin
         @(posedge clk);
         hc += hsyncOut;
         vc += vsyncOut;
      end
      chk("hsync count", hc, 32);
      chk("vsync width", vc, 100);
      chk("syncOe", {31'h0000_0000, syncOe}, 32'h0000_0001);
      complete_run();
   end
endmodule : ssc_sync_mode_ctrl_tb
